/* File: hw/sspv_pkg.sv */
// Package of the strap capture and LED pin block.
// Assumes one pclk domain; constants shared by the top and its synchroniser.
package sspv_pkg;

   // ==========================================================
   // Strap pin positions on the shared pin vector
   localparam int STRAP_N      = 5;
   localparam int PIN_HASH0    = 0;
   localparam int PIN_HASH1    = 1;
   localparam int PIN_FIX_PRI  = 2;
   localparam int PIN_TAG_PRI  = 3;
   localparam int PIN_GROUP    = 4;

   // ==========================================================
   // LED sources driven on the strap pins in LED direct mode
   localparam logic [2:0] LED_DUP_HASH0 = 3'h0;
   localparam logic [2:0] LED_LNK_HASH1 = 3'h7;
   localparam logic [2:0] LED_LNK_FIX   = 3'h0;
   localparam logic [2:0] LED_LNK_TAG   = 3'h1;
   localparam logic [2:0] LED_DUP_GROUP = 3'h3;

   // ==========================================================
   // Hash method codes and port grouping
   localparam logic [1:0] HASH_DIR_CRC0 = 2'h0;
   localparam logic [1:0] HASH_DIR_CRC1 = 2'h1;
   localparam logic [1:0] HASH_CRC_CRC  = 2'h2;
   localparam logic [1:0] HASH_RSVD     = 2'h3;
   localparam logic [2:0] PORT_HI_A     = 3'h6;
   localparam logic [2:0] PORT_HI_B     = 3'h7;
   localparam logic [2:0] PORT_UPLINK   = 3'h7;
   localparam logic [7:0] MASK_UPLINK   = 8'h80;
   localparam logic [7:0] MASK_LEAVES   = 8'h7f;

   // ==========================================================
   // Capture timing: synchroniser depth before the captured sample
   localparam logic [1:0] CAPT_WAIT = 2'h2;

   // ==========================================================
   // APB register map
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam int CTRL_LED_BIT = 0;
   localparam logic CTRL_LED_RST = 1'b1;

   typedef enum logic [0:0] {PH_CAPTURE, PH_ACTIVE} sspv_phase_e;

   // Field order follows the pin positions, so a cast of the pin vector
   // and the status word both line up with the strap numbering
   typedef struct packed {
      logic       port_group_strap;
      logic       tag_priority_strap;
      logic       fixed_port_priority_strap;
      logic [1:0] hash_method_select;
   } sspv_cfg_s;

endpackage : sspv_pkg

/* File: hw/sspv_sync.sv */
// Two-stage synchroniser for the strap pin levels.
// Assumes pins are asynchronous to pclk; reset clears both stages.
`timescale 1ns/100ps
module sspv_sync
   import sspv_pkg::*;
#(
   parameter int N = STRAP_N
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [N-1:0] pin_level,
   output logic      [N-1:0] pin_sync
);

   typedef struct packed {
      logic [N-1:0] meta;
      logic [N-1:0] sync;
   } sspv_sync_s;

   sspv_sync_s q, d;

   // ==========================================================
   // First stage read only by the second
   always_comb begin
      d      = q;
      d.meta = pin_level;
      d.sync = q.meta;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign pin_sync = q.sync;

endmodule : sspv_sync

/* File: hw/sspv_top.sv */
// Strap capture, configuration and LED pin reuse for the switch core.
// Assumes an APB master on pclk and switch status/frame inputs on pclk.
//
// Contract
// [R1] Hash selection 00/01 is direct then CRC, 10 is CRC both, 11 reserved.
// [R2] The hash straps are sampled through reset and held from release; the code clears the synchroniser in reset and captures them with R6 straps.
// [R3] In LED direct mode hash pin 0 shows full duplex of port 0.
// [R4] In LED direct mode hash pin 1 shows link of port 7.
// [R5] With the fixed priority strap set, frames from ports 6 and 7 are high.
// [R6] Priority, tag and group straps are captured at reset release.
// [R7] In LED direct mode the fixed priority pin shows link of port 0.
// [R8] With the tag priority strap set, high priority tags make frames high.
// [R9] In LED direct mode the tag priority pin shows link of port 1.
// [R10] Port grouping is on only when its strap is 1, else one domain.
// [R11] With grouping on, ports 0 to 6 reach only port 7 and port 7 all.
// [R12] In LED direct mode the group pin shows full duplex of port 3.
// [R13] Strap pin changes after reset release are ignored.
`timescale 1ns/100ps
module sspv_top
   import sspv_pkg::*;
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic                     pready,
   output logic      [31:0]         prdata,
   output logic                     pslverr,
   input  wire logic [STRAP_N-1:0]  strap_level,
   output logic      [STRAP_N-1:0]  strap_led,
   output logic      [STRAP_N-1:0]  strap_led_en,
   input  wire logic [7:0]          port_link,
   input  wire logic [7:0]          port_duplex,
   input  wire logic                frame_valid,
   input  wire logic [2:0]          frame_port,
   input  wire logic                frame_tag_high,
   output logic                     cls_valid,
   output logic                     cls_high_pri,
   output logic      [7:0]          cls_fwd_mask,
   output logic                     hash_l1_crc,
   output logic                     hash_l2_crc,
   output logic                     hash_reserved,
   output logic                     cfg_ready
);

   typedef struct packed {
      sspv_phase_e          phase;
      logic [1:0]           cnt;
      sspv_cfg_s            cfg;
      logic                 led_en;
      logic [STRAP_N-1:0]   led;
      logic [STRAP_N-1:0]   led_oe;
      logic                 pready;
      logic [31:0]          prdata;
      logic                 pslverr;
      logic                 cls_valid;
      logic                 cls_high;
      logic [7:0]           cls_mask;
      logic                 l1_crc;
      logic                 l2_crc;
      logic                 rsvd;
   } sspv_state_s;

   sspv_state_s          q, d;
   logic [STRAP_N-1:0]   strap_sync;
   logic                 active;
   logic                 acc;
   logic [7:0]           onehot;

   sspv_sync #(
      .N         (STRAP_N)
   ) u_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin_level (strap_level),
      .pin_sync  (strap_sync)
   );

   assign active = (q.phase == PH_ACTIVE);
   assign acc    = psel & penable;
   assign onehot = 8'h01 << frame_port;

   always_comb begin
      d = q;
      // ========================================================
      // Strap capture: one sample once the synchroniser is full
      case (q.phase)
         PH_CAPTURE: begin
            if (q.cnt == CAPT_WAIT) begin
               d.cfg   = sspv_cfg_s'(strap_sync); // R2 R6
               d.phase = PH_ACTIVE;
            end else begin
               d.cnt = q.cnt + 2'h1;
            end
         end
         PH_ACTIVE: begin
            d.phase = PH_ACTIVE; // R13
         end
         default: begin
            d.phase = PH_CAPTURE;
         end
      endcase

      // ========================================================
      // Hash method decode; reserved code falls back to default
      d.l1_crc = (q.cfg.hash_method_select == HASH_CRC_CRC); // R1
      d.l2_crc = 1'b1; // R1
      d.rsvd   = (q.cfg.hash_method_select == HASH_RSVD); // R1

      // ========================================================
      // LED direct mode; pins stay inputs until straps are taken
      d.led_oe = (active && q.led_en) ? '1 : '0;
      d.led[PIN_HASH0]   = port_duplex[LED_DUP_HASH0]; // R3
      d.led[PIN_HASH1]   = port_link[LED_LNK_HASH1]; // R4
      d.led[PIN_FIX_PRI] = port_link[LED_LNK_FIX]; // R7
      d.led[PIN_TAG_PRI] = port_link[LED_LNK_TAG]; // R9
      d.led[PIN_GROUP]   = port_duplex[LED_DUP_GROUP]; // R12

      // ========================================================
      // Frame class and forwarding mask
      d.cls_valid = frame_valid;
      d.cls_high  = (q.cfg.fixed_port_priority_strap &&
                     (frame_port == PORT_HI_A ||
                      frame_port == PORT_HI_B)) || // R5
                    (q.cfg.tag_priority_strap && frame_tag_high); // R8
      if (!q.cfg.port_group_strap) begin
         d.cls_mask = ~onehot; // R10
      end else if (frame_port == PORT_UPLINK) begin
         d.cls_mask = MASK_LEAVES; // R11
      end else begin
         d.cls_mask = MASK_UPLINK; // R11
      end

      // ========================================================
      // APB slave: one wait state, write lands with pready
      d.pready  = acc && !q.pready;
      d.pslverr = 1'b0;
      d.prdata  = '0;
      if (acc && !q.pready) begin
         case (paddr)
            REG_CTRL: begin
               d.prdata[CTRL_LED_BIT] = q.led_en;
            end
            REG_STATUS: begin
               d.prdata[6:0] = {active, q.rsvd, q.cfg};
            end
            default: begin
               d.pslverr = 1'b1;
            end
         endcase
      end
      if (acc && q.pready && pwrite && paddr == REG_CTRL) begin
         d.led_en = pwdata[CTRL_LED_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q        <= '0;
         q.phase  <= PH_CAPTURE;
         q.led_en <= CTRL_LED_RST;
      end else begin
         q <= d;
      end
   end

   assign pready        = q.pready;
   assign prdata        = q.prdata;
   assign pslverr       = q.pslverr;
   assign strap_led     = q.led;
   assign strap_led_en  = q.led_oe;
   assign cls_valid     = q.cls_valid;
   assign cls_high_pri  = q.cls_high;
   assign cls_fwd_mask  = q.cls_mask;
   assign hash_l1_crc   = q.l1_crc;
   assign hash_l2_crc   = q.l2_crc;
   assign hash_reserved = q.rsvd;
   assign cfg_ready     = active;

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_settled;
      active ##1 active;
   endsequence

   a_hash_decode: assert property (s_settled |-> // R1
      hash_l1_crc == (q.cfg.hash_method_select == HASH_CRC_CRC) &&
      hash_reserved == (q.cfg.hash_method_select == HASH_RSVD))
      else $error("hash decode wrong");
   a_hash_hold: assert property (s_settled |-> // R2
      $stable(q.cfg.hash_method_select))
      else $error("hash selection moved");
   a_dup0_led: assert property (active && q.led_en |=> // R3
      strap_led_en[PIN_HASH0] &&
      strap_led[PIN_HASH0] == $past(port_duplex[0]))
      else $error("port 0 duplex led wrong");
   a_lnk7_led: assert property (active && q.led_en |=> // R4
      strap_led[PIN_HASH1] == $past(port_link[7]))
      else $error("port 7 link led wrong");
   a_fixed_pri: assert property (frame_valid && // R5
      q.cfg.fixed_port_priority_strap && frame_port[2:1] == 2'h3
      |=> cls_valid && cls_high_pri)
      else $error("fixed port priority missed");
   a_capture_val: assert property ($rose(active) |-> // R6
      q.cfg == $past(strap_sync))
      else $error("strap capture wrong");
   a_capture_time: assert property ($rose(presetn) |-> // R6
      !active [*3] ##1 active)
      else $error("capture timing wrong");
   a_lnk0_led: assert property (active && q.led_en |=> // R7
      strap_led[PIN_FIX_PRI] == $past(port_link[0]))
      else $error("port 0 link led wrong");
   a_tag_pri: assert property (frame_valid && // R8
      !q.cfg.tag_priority_strap && frame_port < PORT_HI_A
      |=> !cls_high_pri)
      else $error("tag priority while off");
   a_lnk1_led: assert property (active && q.led_en |=> // R9
      strap_led[PIN_TAG_PRI] == $past(port_link[1]))
      else $error("port 1 link led wrong");
   a_one_domain: assert property (!q.cfg.port_group_strap // R10
      |=> cls_fwd_mask == ~$past(onehot))
      else $error("single domain mask wrong");
   a_group_leaf: assert property (q.cfg.port_group_strap && // R11
      frame_port != PORT_UPLINK |=> cls_fwd_mask == MASK_UPLINK)
      else $error("group mask wrong");
   a_dup3_led: assert property (active && q.led_en |=> // R12
      strap_led[PIN_GROUP] == $past(port_duplex[3]))
      else $error("port 3 duplex led wrong");
   a_cfg_frozen: assert property (s_settled |-> $stable(q.cfg)) // R13
      else $error("config changed after capture");
   a_no_drive: assert property (!active |=> strap_led_en == '0)
      else $error("strap pin driven during capture");

endmodule : sspv_top

/* File: verification/sspv_board.sv */
// Board side of the strap pins: pull resistors and LED loads.
// Assumes the block's LED value and enable per pin; pulls win when released.
`timescale 1ns/100ps
module sspv_board
   import sspv_pkg::*;
(
   input  wire logic [STRAP_N-1:0] pull_level,
   input  wire logic [STRAP_N-1:0] led,
   input  wire logic [STRAP_N-1:0] led_en,
   output logic      [STRAP_N-1:0] pin
);
   // ==========================================================
   // Wire level: driver first, resistor when the pin floats
   always_comb begin
      for (int i = 0; i < STRAP_N; i++) begin
         pin[i] = led_en[i] ? led[i] : pull_level[i];
      end
   end
endmodule : sspv_board

/* File: verification/switch_strap_priority_vlan_config_tb.sv */
// Self-checking bench of the strap capture block with its board model.
// Assumes APB at 100 MHz and strap pins resolved by the board model.
`timescale 1ns/100ps
module switch_strap_priority_vlan_config_tb;
   import sspv_pkg::*;
   logic               pclk, presetn, psel, penable, pwrite;
   logic [7:0]         paddr, port_link, port_duplex, cls_fwd_mask;
   logic [31:0]        pwdata, prdata, rd;
   logic               pready, pslverr, err, frame_valid, frame_tag_high;
   logic [2:0]         frame_port;
   logic               cls_valid, cls_high_pri, cfg_ready;
   logic               hash_l1_crc, hash_l2_crc, hash_reserved;
   logic [STRAP_N-1:0] pull, pin, led, led_en;
   int                 bad_count, num_checks;

   sspv_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .strap_level(pin), .strap_led(led), .strap_led_en(led_en),
      .port_link(port_link), .port_duplex(port_duplex),
      .frame_valid(frame_valid), .frame_port(frame_port),
      .frame_tag_high(frame_tag_high), .cls_valid(cls_valid),
      .cls_high_pri(cls_high_pri), .cls_fwd_mask(cls_fwd_mask),
      .hash_l1_crc(hash_l1_crc), .hash_l2_crc(hash_l2_crc),
      .hash_reserved(hash_reserved), .cfg_ready(cfg_ready));
   sspv_board u_board (.pull_level(pull), .led(led), .led_en(led_en),
      .pin(pin));

   // ==========================================================
   // Clock, watchdog, shared tasks
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      #200000;
      bad_count++;
      test_done();
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   // Master waits on pready only; the watchdog ends a hang
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic do_reset(input logic [STRAP_N-1:0] p);
      int n;
      n = 0;
      @(posedge pclk);
      presetn <= 1'b0; pull <= p;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (cfg_ready !== 1'b1 && n < 10);
      check(cfg_ready, 1'b1);
      repeat (2) @(posedge pclk);
   endtask : do_reset

   // ==========================================================
   // Scenarios
   task automatic test_hash(input logic [1:0] c, input logic [2:0] s);
      check({hash_l1_crc, hash_l2_crc}, {c == HASH_CRC_CRC, 1'b1});
      check(hash_reserved, c == HASH_RSVD);
      apb(1'b0, REG_STATUS, 32'h0);
      check(rd[6:0], {1'b1, c == HASH_RSVD, s, c});
   endtask : test_hash
   task automatic test_classify(input logic [2:0] s);
      logic [7:0] em;
      for (int p = 0; p < 8; p++) begin
         for (int t = 0; t < 2; t++) begin
            @(posedge pclk);
            frame_valid <= 1'b1; frame_port <= p[2:0]; frame_tag_high <= t[0];
            @(posedge pclk);
            frame_valid <= 1'b0;
            #1;
            if (!s[2]) em = 8'hff & ~(8'h01 << p);
            else em = (p == 7) ? MASK_LEAVES : MASK_UPLINK;
            check(cls_valid, 1'b1);
            check(cls_high_pri, (s[0] && p >= 6) || (s[1] && t == 1));
            check(cls_fwd_mask, em);
         end
      end
   endtask : test_classify
   task automatic test_leds();
      for (int k = 0; k < 2; k++) begin
         @(posedge pclk);
         port_link <= k ? 8'h7c : 8'h83; port_duplex <= k ? 8'hf6 : 8'h09;
         repeat (2) @(posedge pclk);
         #1;
         check(led_en, 5'h1f);
         check(led[0], port_duplex[0]);
         check(led[1], port_link[7]);
         check(led[2], port_link[0]);
         check(led[3], port_link[1]);
         check(led[4], port_duplex[3]);
      end
      apb(1'b1, REG_CTRL, 32'h0);
      repeat (2) @(posedge pclk);
      #1;
      check(led_en, 5'h00);
      apb(1'b0, REG_CTRL, 32'h0);
      check(err, 1'b0);
      check(rd, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      apb(1'b1, REG_CTRL, 32'h1);
      apb(1'b0, REG_CTRL, 32'h0);
      check(rd, 32'h1);
   endtask : test_leds
   task automatic test_late_straps();
      do_reset(5'h15);
      // LEDs off so the pins show the new pulls to the block
      apb(1'b1, REG_CTRL, 32'h0);
      pull <= 5'h0a;
      repeat (4) @(posedge pclk);
      apb(1'b0, REG_STATUS, 32'h0);
      check(rd[6:0], 7'h55);
      check({hash_l1_crc, hash_reserved}, 2'b00);
   endtask : test_late_straps

   // ==========================================================
   // Main sequence: every hash code and every fixed, tag and group strap combination
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h0; pwdata = 32'h0; port_link = 8'h0; port_duplex = 8'h0;
      frame_valid = 1'b0; frame_port = 3'h0; frame_tag_high = 1'b0;
      pull = 5'h0; bad_count = 0; num_checks = 0;
      for (int i = 0; i < 8; i++) begin
         do_reset({i[2:0], i[1:0]});
         test_hash(i[1:0], i[2:0]);
         test_classify(i[2:0]);
      end
      test_leds();
      test_late_straps();
      test_done();
   end
endmodule : switch_strap_priority_vlan_config_tb
